//--- inc/fepc_params.svh
// Constants for the fast ethernet phy coding path
`ifndef FEPC_PARAMS_SVH
`define FEPC_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FEPC_MCLK_MHZ        50
`define FEPC_MCLK_NS         20
`define FEPC_SYNC_TMO_US     40
`define FEPC_SYNC_TMO_CYC    ((`FEPC_SYNC_TMO_US * `FEPC_MCLK_MHZ))
`define FEPC_TX10_CLK_NS     400
`define FEPC_TX10_HALF_CYC   ((`FEPC_TX10_CLK_NS / 2) / `FEPC_MCLK_NS)
`define FEPC_NLP_PERIOD_US   16000
`define FEPC_NLP_WIDTH_NS    100
`define FEPC_NLP_WIDTH_CYC   ((`FEPC_NLP_WIDTH_NS + `FEPC_MCLK_NS - 1) / `FEPC_MCLK_NS)
`define FEPC_RXCLK_LOW_CYC   2'h2
`define FEPC_LOCK_BITS       6'h20
`define FEPC_IDLE_ONES       4'hA

// ----------------------------------------------------------------
// Code-groups and nibbles
// ----------------------------------------------------------------
`define FEPC_CG_J            5'h18
`define FEPC_CG_K            5'h11
`define FEPC_CG_T            5'h0D
`define FEPC_CG_R            5'h07
`define FEPC_CG_I            5'h1F
`define FEPC_NIB_PRE         4'h5
`define FEPC_NIB_BAD_SSD     4'hE

// ----------------------------------------------------------------
// Line levels
// ----------------------------------------------------------------
`define FEPC_LVL_ZERO        2'h0
`define FEPC_LVL_POS         2'h1
`define FEPC_LVL_NEG         2'h3

`endif

//--- inc/fepc_pkg.sv
// Types of the fast ethernet phy coding path
`include "fepc_params.svh"

package fepc_pkg;

    typedef enum logic [1:0]
    {
        FEPC_HUNT  = 2'b01,
        FEPC_FRAME = 2'b10
    } fepc_rx_st_t;

    typedef struct packed
    {
        logic [4:0]  tx_sh;
        logic [2:0]  tx_cnt;
        logic        tx_nrzi;
        logic [1:0]  tx_ph;
        logic [1:0]  tx_mlt3;
        logic        tx_take;
        logic [1:0]  rx_prev;
        logic [10:0] key;
        logic        lock;
        logic [5:0]  lk_cnt;
        logic [3:0]  ones;
        logic [10:0] tmo;
        logic [9:0]  sh;
        fepc_rx_st_t st;
        logic [2:0]  gcnt;
        logic [4:0]  pend;
        logic        pend_v;
        logic        pend_er;
        logic        t_seen;
        logic        i_seen;
        logic [3:0]  rxd;
        logic        rx_er;
        logic        rx_dv;
        logic        crs;
        logic        col;
        logic        rx_clk;
        logic [1:0]  rclk_cnt;
        logic [1:0]  rmii_rxd;
        logic [1:0]  rmii_hi;
        logic        rmii_hi_v;
        logic        crs_dv;
        logic [3:0]  div;
        logic        tx_clk;
        logic [1:0]  rmii_lo;
        logic        rmii_ph;
        logic [3:0]  hold;
        logic        hold_v;
        logic [3:0]  msh;
        logic [2:0]  mbits;
        logic        mhalf;
        logic        mact;
        logic        man_out;
        logic [19:0] nlp_cnt;
        logic [2:0]  nlp_w;
    } fepc_state_t;

endpackage

//--- design/fepc_top.sv
// Coding datapath of a 10/100 ethernet phy: 100M line coding, 100M receive, 10M transmit
`include "fepc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fepc_top
#(
    parameter int NLP_PERIOD_CYC = `FEPC_NLP_PERIOD_US * `FEPC_MCLK_MHZ
)
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       line_bit_stb,
    input  wire logic [4:0] tx_cg,
    input  wire logic       tx_cg_valid,
    output logic            tx_cg_take,
    output logic            tx_nrzi,
    output logic [1:0]      tx_mlt3,
    input  wire logic       rx_bit_stb,
    input  wire logic [1:0] rx_mlt3,
    input  wire logic       line_signal_detect,
    input  wire logic       link_fail,
    input  wire logic       descr_bypass,
    input  wire logic       decode_enable,
    input  wire logic       rmii_mode,
    input  wire logic       ten_meg_mode,
    input  wire logic       half_duplex,
    output logic [3:0]      rxd,
    output logic            rx_error_or_fifth_bit,
    output logic            rx_dv,
    output logic            crs,
    output logic            col,
    output logic            rx_clk,
    output logic [1:0]      rmii_rxd,
    output logic            crs_dv,
    output logic            tx_clk,
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    input  wire logic [1:0] rmii_txd,
    input  wire logic       ten_half_stb,
    output logic            ten_meg_tx_encoder_out
);

    fepc_pkg::fepc_state_t s;
    fepc_pkg::fepc_state_t n;
    logic                  ssd_ev;
    logic                  bad_ev;
    logic                  tmo_ev;

    // ----------------------------------------------------------------
    // 5B to 4B table, {valid, nibble}
    // ----------------------------------------------------------------
    function automatic logic [4:0] fepc_dec(input logic [4:0] c);
        unique case (c)
            5'h1E: fepc_dec = 5'h10;
            5'h09: fepc_dec = 5'h11;
            5'h14: fepc_dec = 5'h12;
            5'h15: fepc_dec = 5'h13;
            5'h0A: fepc_dec = 5'h14;
            5'h0B: fepc_dec = 5'h15;
            5'h0E: fepc_dec = 5'h16;
            5'h0F: fepc_dec = 5'h17;
            5'h12: fepc_dec = 5'h18;
            5'h13: fepc_dec = 5'h19;
            5'h16: fepc_dec = 5'h1A;
            5'h17: fepc_dec = 5'h1B;
            5'h1A: fepc_dec = 5'h1C;
            5'h1B: fepc_dec = 5'h1D;
            5'h1C: fepc_dec = 5'h1E;
            5'h1D: fepc_dec = 5'h1F;
            default: fepc_dec = 5'h00;
        endcase
    endfunction

    always_comb
    begin
        logic       tb;
        logic       rb;
        logic       pred;
        logic       d;
        logic       ok;
        logic       ev;
        logic       ev_dv;
        logic       ev_er;
        logic       ev_b4;
        logic       endf;
        logic       byp;
        logic       rise;
        logic       wrap;
        logic [3:0] ev_nib;
        logic [4:0] cg;
        logic [4:0] dc;
        logic [9:0] shn;
        tb = 1'b0;
        rb = 1'b0;
        pred = 1'b0;
        d = 1'b0;
        ok = 1'b0;
        ev = 1'b0;
        ev_dv = 1'b0;
        ev_er = 1'b0;
        ev_b4 = 1'b0;
        endf = 1'b0;
        byp = !decode_enable && !rmii_mode;
        rise = 1'b0;
        wrap = 1'b0;
        ev_nib = 4'h0;
        cg = 5'h00;
        dc = 5'h00;
        shn = s.sh;
        ssd_ev = 1'b0;
        bad_ev = 1'b0;
        tmo_ev = 1'b0;
        n = s;
        n.tx_take = 1'b0;

        // ----------------------------------------------------------------
        // 100M transmit: code-group to NRZI and three-level line code
        // ----------------------------------------------------------------
        if (line_bit_stb)
        begin
            if (s.tx_cnt == 3'h0)
            begin
                // Without a code-group the line carries idle ones
                cg = tx_cg_valid ? tx_cg : `FEPC_CG_I;
                n.tx_take = tx_cg_valid;
                tb = cg[4];
                n.tx_sh = {cg[3:0], 1'b0};
                n.tx_cnt = 3'h4;
            end
            else
            begin
                tb = s.tx_sh[4];
                n.tx_sh = {s.tx_sh[3:0], 1'b0};
                n.tx_cnt = s.tx_cnt - 3'h1;
            end
            n.tx_nrzi = s.tx_nrzi ^ tb;
            n.tx_ph = s.tx_ph + {1'b0, tb};
            n.tx_mlt3 = n.tx_ph[0] ? (n.tx_ph[1] ? `FEPC_LVL_NEG : `FEPC_LVL_POS)
                                   : `FEPC_LVL_ZERO;
        end

        // ----------------------------------------------------------------
        // 100M receive: level decode, descrambler, alignment, decode
        // ----------------------------------------------------------------
        if (!line_signal_detect || link_fail)
        begin
            n.lock = 1'b0;
            n.lk_cnt = 6'h00;
            n.tmo = 11'h000;
            n.st = fepc_pkg::FEPC_HUNT;
            n.pend_v = 1'b0;
            endf = s.st == fepc_pkg::FEPC_FRAME;
        end
        else if (rx_bit_stb)
        begin
            rb = rx_mlt3 != s.rx_prev;
            n.rx_prev = rx_mlt3;
            pred = s.key[10] ^ s.key[8];
            if (descr_bypass)
                d = rb;
            else if (!s.lock)
            begin
                // Scrambled idle: key bit is the inverted line bit
                n.key = {s.key[9:0], ~rb};
                n.lk_cnt = (~rb == pred) ? s.lk_cnt + 6'h01 : 6'h00;
                n.lock = n.lk_cnt == `FEPC_LOCK_BITS;
            end
            else
            begin
                n.key = {s.key[9:0], pred};
                d = rb ^ pred;
            end
            ok = descr_bypass || s.lock;
            n.ones = !d ? 4'h0 : (s.ones == `FEPC_IDLE_ONES ? s.ones : s.ones + 4'h1);
            shn = {s.sh[8:0], d};
            n.sh = shn;
            cg = shn[4:0];
            dc = fepc_dec(cg);
            if (ok)
            begin
                unique case (s.st)
                    fepc_pkg::FEPC_HUNT:
                    begin
                        if (shn[9:5] == `FEPC_CG_J)
                        begin
                            ev = 1'b1;
                            if (cg == `FEPC_CG_K)
                            begin
                                ssd_ev = 1'b1;
                                n.st = fepc_pkg::FEPC_FRAME;
                                n.gcnt = 3'h0;
                                ev_nib = `FEPC_NIB_PRE;
                                ev_dv = 1'b1;
                                n.pend = {1'b0, `FEPC_NIB_PRE};
                                n.pend_v = 1'b1;
                                n.pend_er = 1'b0;
                                n.t_seen = 1'b0;
                                n.i_seen = 1'b0;
                                n.crs = 1'b1;
                            end
                            else
                            begin
                                bad_ev = 1'b1;
                                ev_nib = `FEPC_NIB_BAD_SSD;
                                ev_er = 1'b1;
                            end
                        end
                    end
                    fepc_pkg::FEPC_FRAME:
                    begin
                        n.gcnt = s.gcnt + 3'h1;
                        if (s.gcnt == 3'h4)
                        begin
                            n.gcnt = 3'h0;
                            ev = s.pend_v;
                            ev_nib = s.pend[3:0];
                            ev_b4 = s.pend[4];
                            ev_er = s.pend_er;
                            ev_dv = 1'b1;
                            n.pend = byp ? cg : {cg[4], dc[3:0]};
                            n.pend_v = 1'b1;
                            n.pend_er = 1'b0;
                            n.t_seen = cg == `FEPC_CG_T;
                            n.i_seen = cg == `FEPC_CG_I;
                            if (s.t_seen && cg == `FEPC_CG_R)
                                endf = 1'b1;
                            else if (s.i_seen && cg == `FEPC_CG_I)
                                endf = 1'b1;
                            else if (s.t_seen)
                                n.pend_er = 1'b1;
                            else if (n.t_seen || n.i_seen)
                                n.pend_v = 1'b0;
                            else if (!dc[4] && !byp)
                                n.pend_er = 1'b1;
                            if (endf)
                            begin
                                n.pend_v = 1'b0;
                                n.st = fepc_pkg::FEPC_HUNT;
                            end
                        end
                    end
                    default:
                        n.st = fepc_pkg::FEPC_HUNT;
                endcase
            end
        end

        // Idle watchdog: a frame longer than the window loses sync
        if (s.lock && !descr_bypass && line_signal_detect && !link_fail)
        begin
            n.tmo = (n.ones == `FEPC_IDLE_ONES) ? 11'h000 : s.tmo + 11'h001;
            if (s.tmo == 11'(`FEPC_SYNC_TMO_CYC - 1))
            begin
                tmo_ev = 1'b1;
                n.lock = 1'b0;
                n.lk_cnt = 6'h00;
                n.tmo = 11'h000;
                n.st = fepc_pkg::FEPC_HUNT;
                n.pend_v = 1'b0;
                endf = s.st == fepc_pkg::FEPC_FRAME;
                ev = 1'b0;
                // Abort wins over a delimiter seen in the same cycle, except that crs raised by a start pair stays set
                ssd_ev = 1'b0;
                bad_ev = 1'b0;
            end
        end

        // ----------------------------------------------------------------
        // 10M transmit intake, loopback and Manchester encoder
        // ----------------------------------------------------------------
        wrap = s.div == 4'(`FEPC_TX10_HALF_CYC - 1);
        n.div = wrap ? 4'h0 : s.div + 4'h1;
        n.tx_clk = wrap ? !s.tx_clk : s.tx_clk;
        rise = wrap && !s.tx_clk;
        if (ten_half_stb)
        begin
            if (!s.mhalf)
            begin
                if (s.mbits == 3'h0)
                begin
                    n.mact = s.hold_v;
                    n.msh = s.hold;
                    n.hold_v = 1'b0;
                    n.mbits = s.hold_v ? 3'h4 : 3'h0;
                end
                n.mhalf = n.mact;
                if (n.mact)
                    n.man_out = ~n.msh[0];
            end
            else
            begin
                n.man_out = s.msh[0];
                n.msh = {1'b0, s.msh[3:1]};
                n.mbits = s.mbits - 3'h1;
                n.mhalf = 1'b0;
            end
        end
        if (ten_meg_mode && rmii_mode)
        begin
            if (!tx_en)
                n.rmii_ph = 1'b0;
            else if (wrap && !s.rmii_ph)
            begin
                n.rmii_lo = rmii_txd;
                n.rmii_ph = 1'b1;
            end
            else if (wrap)
            begin
                n.hold = {rmii_txd, s.rmii_lo};
                n.hold_v = 1'b1;
                n.rmii_ph = 1'b0;
            end
        end
        else if (ten_meg_mode && rise && tx_en)
        begin
            n.hold = txd;
            n.hold_v = 1'b1;
            if (half_duplex)
            begin
                ev = 1'b1;
                ev_nib = txd;
                ev_dv = 1'b1;
            end
        end
        if (ten_meg_mode && !tx_en && !n.mact)
        begin
            n.nlp_cnt = s.nlp_cnt + 20'h00001;
            if (s.nlp_cnt == 20'(NLP_PERIOD_CYC - 1))
            begin
                n.nlp_cnt = 20'h00000;
                n.nlp_w = 3'(`FEPC_NLP_WIDTH_CYC);
            end
        end
        else
            n.nlp_cnt = 20'h00000;
        if (s.nlp_w != 3'h0)
            n.nlp_w = s.nlp_w - 3'h1;
        if (!n.mact)
            n.man_out = n.nlp_w != 3'h0;

        // ----------------------------------------------------------------
        // MII and RMII receive launch
        // ----------------------------------------------------------------
        n.col = 1'b0;
        if (ten_meg_mode && half_duplex && !rmii_mode)
            n.crs = tx_en;
        if (ev)
        begin
            n.rxd = ev_nib;
            // Fifth bit for every valid nibble when decoding is bypassed; a bad start keeps its error
            n.rx_er = (byp && ev_dv) ? ev_b4 : ev_er;
            n.rx_dv = ev_dv;
            n.rx_clk = 1'b0;
            n.rclk_cnt = `FEPC_RXCLK_LOW_CYC;
            n.rmii_rxd = ev_nib[1:0];
            n.rmii_hi = ev_nib[3:2];
            n.rmii_hi_v = 1'b1;
            n.crs_dv = ev_dv;
        end
        else
        begin
            n.rmii_hi_v = 1'b0;
            if (s.rmii_hi_v)
                n.rmii_rxd = s.rmii_hi;
            if (line_signal_detect && !ten_meg_mode)
            begin
                n.rclk_cnt = (s.rclk_cnt == 2'h0) ? 2'h0 : s.rclk_cnt - 2'h1;
                n.rx_clk = s.rclk_cnt == 2'h0;
            end
            else
                n.rx_clk = !s.rx_clk;
            if (ten_meg_mode && !tx_en)
                n.rx_dv = 1'b0;
        end
        if (endf)
        begin
            n.rx_dv = 1'b0;
            n.crs = 1'b0;
            n.crs_dv = 1'b0;
            n.rx_er = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.st <= fepc_pkg::FEPC_HUNT;
        end
        else
            s <= n;
    end

    assign tx_cg_take = s.tx_take;
    assign tx_nrzi = s.tx_nrzi;
    assign tx_mlt3 = s.tx_mlt3;
    assign rxd = s.rxd;
    assign rx_error_or_fifth_bit = s.rx_er;
    assign rx_dv = s.rx_dv;
    assign crs = s.crs;
    assign col = s.col;
    assign rx_clk = s.rx_clk;
    assign rmii_rxd = s.rmii_rxd;
    assign crs_dv = s.crs_dv;
    assign tx_clk = s.tx_clk;
    assign ten_meg_tx_encoder_out = s.man_out;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_mlt_follow:   assert property (##1 ((tx_nrzi != $past(tx_nrzi)) == (tx_mlt3 != $past(tx_mlt3))))
        else $error("line level step does not follow NRZI change");
    chk_line_hold:    assert property (!line_bit_stb |=> $stable(tx_nrzi) && $stable(tx_mlt3))
        else $error("line output moved without a bit strobe");
    chk_bad_start:    assert property (bad_ev |=> rx_error_or_fifth_bit && rxd == 4'hE && !rx_dv)
        else $error("bad start pair not reported");
    chk_start_pre:    assert property (ssd_ev |=> rx_dv && rxd == 4'h5 && crs)
        else $error("start pair did not give preamble nibble");
    chk_detect_drop:  assert property (!line_signal_detect && !ten_meg_mode |=> !rx_dv && !crs)
        else $error("valid held without signal detect");
    chk_no_collide:   assert property (!col)
        else $error("collision raised");
    chk_sync_tmo:     assert property (tmo_ev |=> !s.lock ##1 !s.lock)
        else $error("timeout did not drop lock");
    chk_rmii_ignore:  assert property (rmii_mode && !tx_en |=> $stable(s.hold) && !s.rmii_ph)
        else $error("di-bit taken while enable low");
    chk_ref_clock:    assert property (!line_signal_detect && !ten_meg_mode |=> rx_clk != $past(rx_clk))
        else $error("receive clock not free running");
    chk_man_half:     assert property
        (s.mact && s.mhalf && ten_half_stb
            |=> ten_meg_tx_encoder_out != $past(ten_meg_tx_encoder_out))
        else $error("second Manchester half did not invert");

    cov_frame_start:  cover property (ssd_ev);
    cov_frame_end:    cover property ($fell(rx_dv) && !ten_meg_mode);
    cov_bad_start:    cover property (bad_ev);
    cov_link_pulse:   cover property ($rose(ten_meg_tx_encoder_out) && !tx_en);

endmodule

`default_nettype wire

//--- verif/fepc_mac_model.sv
// Controller transmit side model for the coding path bench
`timescale 1ns/1ps
`default_nettype none

module fepc_mac_model
(
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic       tx_clk,
    output logic            tx_en,
    output logic [3:0]      txd
);
    logic       prev = 1'b0;
    logic       en_q = 1'b0;
    logic [3:0] d_q = 4'h3;
    assign tx_en = en_q;
    assign txd = d_q;
    // Moves only after the latching edge; data inverts when not enabled
    always @(posedge mclk)
    begin
        prev <= tx_clk;
        if (tx_clk && !prev)
        begin
            en_q <= go;
            d_q <= go ? d_q + 4'h1 : ~d_q;
        end
    end
endmodule

`default_nettype wire

//--- verif/fepc_top_tb_top.sv
// Self-checking bench of the coding path
`include "fepc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fepc_top_tb_top;
    logic       mclk = 1'b0, nrst = 1'b0, line_bit_stb = 1'b0, tx_cg_valid = 1'b0;
    logic       rx_bit_stb = 1'b0, sig_det = 1'b1, descr_bypass = 1'b0, go = 1'b0;
    logic       ten_meg_mode = 1'b0, half_duplex = 1'b0, ten_half_stb = 1'b0;
    logic [4:0] tx_cg = 5'h1F;
    logic [1:0] rx_mlt3 = 2'h0, ri = 2'h0;
    logic       tx_cg_take, tx_nrzi, rx_er, rx_dv, crs, col, tx_clk, tx_en, enc_out;
    logic       rmii_mode = 1'b0, dec_en = 1'b1, scr = 1'b0, rx_clk, crs_dv;
    logic [1:0] rmii_txd = 2'h0, rmii_rxd;
    logic [10:0] skey = 11'h001;
    logic [1:0] tx_mlt3;
    logic [3:0] rxd, txd;
    logic [1:0] lvl [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
    int         fail_count = 0, checks = 0;

    always #10 mclk = ~mclk;
    always @(posedge mclk) ten_half_stb <= ~ten_half_stb;

    fepc_top #(.NLP_PERIOD_CYC(50)) i_dut
    (
        .mclk, .nrst, .line_bit_stb, .tx_cg, .tx_cg_valid, .tx_cg_take, .tx_nrzi, .tx_mlt3,
        .rx_bit_stb, .rx_mlt3, .line_signal_detect(sig_det), .link_fail(1'b0),
        .descr_bypass, .decode_enable(dec_en), .rmii_mode, .ten_meg_mode, .half_duplex,
        .rxd, .rx_error_or_fifth_bit(rx_er), .rx_dv, .crs, .col, .rx_clk, .rmii_rxd,
        .crs_dv, .tx_clk, .tx_en, .txd, .rmii_txd, .ten_half_stb,
        .ten_meg_tx_encoder_out(enc_out)
    );

    fepc_mac_model i_mac (.mclk, .go, .tx_clk, .tx_en, .txd);

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic t_tx100;
        logic n;
        logic [1:0] i;
        logic b;
        logic [4:0] cg;
        n = 1'b0;
        i = 2'h0;
        cg = 5'h0B;
        tx_cg <= cg;
        tx_cg_valid <= 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            b = cg[4 - k % 5];
            line_bit_stb <= 1'b1;
            @(posedge mclk);
            line_bit_stb <= 1'b0;
            n = n ^ b;
            i = i + 2'(b);
            #1;
            check("take", 4'(tx_cg_take), 4'(k % 5 == 0));
            check("nrzi", 4'(tx_nrzi), 4'(n));
            check("mlt3", 4'(tx_mlt3), 4'(lvl[i]));
            @(posedge mclk);
        end
        tx_cg_valid <= 1'b0;
    endtask

    task automatic send_cg(input logic [4:0] cg);
        logic kb;
        for (int k = 4; k >= 0; k--)
        begin
            // Same free-running key as the far transmitter
            kb = skey[10] ^ skey[8];
            if (scr)
                skey = {skey[9:0], kb};
            ri = ri + 2'(cg[k] ^ (scr & kb));
            rx_mlt3 <= lvl[ri];
            rx_bit_stb <= 1'b1;
            @(posedge mclk);
            rx_bit_stb <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic t_rx100;
        descr_bypass <= 1'b1;
        repeat (3) send_cg(`FEPC_CG_I);
        send_cg(`FEPC_CG_J);
        send_cg(`FEPC_CG_K);
        #1;
        check("dv", 4'(rx_dv), 4'h1);
        check("rxd", rxd, `FEPC_NIB_PRE);
        check("rxclk", 4'(rx_clk), 4'h0);
        @(posedge mclk);
        send_cg(5'h16);
        send_cg(5'h1A);
        #1;
        check("rxd", rxd, 4'hA);
        check("dv", 4'(rx_dv), 4'h1);
        @(posedge mclk);
        dec_en <= 1'b0;
        repeat (2) send_cg(5'h17);
        #1;
        check("rxd", rxd, 4'h7);
        check("er", 4'(rx_er), 4'h1);
        @(posedge mclk);
        dec_en <= 1'b1;
        send_cg(`FEPC_CG_T);
        send_cg(`FEPC_CG_R);
        for (int k = 0; k < 20 && rx_dv !== 1'b0; k++)
        begin
            @(posedge mclk);
            #1;
        end
        #1;
        check("dv", 4'(rx_dv), 4'h0);
        check("crs", 4'(crs), 4'h0);
        @(posedge mclk);
        repeat (2) send_cg(`FEPC_CG_I);
        send_cg(`FEPC_CG_J);
        send_cg(`FEPC_CG_K);
        sig_det <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("dv", 4'(rx_dv), 4'h0);
        @(posedge mclk);
        sig_det <= 1'b1;
    endtask

    task automatic t_bad_ssd;
        repeat (3) send_cg(`FEPC_CG_I);
        send_cg(`FEPC_CG_J);
        send_cg(5'h16);
        for (int k = 0; k < 20 && rx_er !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
        end
        #1;
        check("er", 4'(rx_er), 4'h1);
        check("rxd", rxd, `FEPC_NIB_BAD_SSD);
        check("dv", 4'(rx_dv), 4'h0);
        @(posedge mclk);
        repeat (2) send_cg(`FEPC_CG_I);
    endtask

    task automatic t_lock;
        descr_bypass <= 1'b0;
        scr = 1'b1;
        repeat (12) send_cg(`FEPC_CG_I);
        send_cg(`FEPC_CG_J);
        send_cg(`FEPC_CG_K);
        #1;
        check("dv", 4'(rx_dv), 4'h1);
        @(posedge mclk);
        // Data without idle outlasts the sync window
        repeat (205) send_cg(5'h16);
        #1;
        check("dv", 4'(rx_dv), 4'h0);
        @(posedge mclk);
        descr_bypass <= 1'b1;
        scr = 1'b0;
    endtask

    task automatic t_rmii;
        rmii_mode <= 1'b1;
        rmii_txd <= 2'h3;
        repeat (2) send_cg(`FEPC_CG_I);
        send_cg(`FEPC_CG_J);
        send_cg(`FEPC_CG_K);
        send_cg(5'h0E);
        send_cg(5'h1A);
        #1;
        check("rmii", 4'(rmii_rxd), 4'h1);
        check("crsdv", 4'(crs_dv), 4'h1);
        @(posedge mclk);
        send_cg(`FEPC_CG_T);
        send_cg(`FEPC_CG_R);
        #1;
        check("crsdv", 4'(crs_dv), 4'h0);
        @(posedge mclk);
        ten_meg_mode <= 1'b1;
        repeat (40) @(posedge mclk);
        ten_meg_mode <= 1'b0;
        rmii_mode <= 1'b0;
        rmii_txd <= 2'h0;
    endtask

    task automatic t_ten;
        logic p;
        int n;
        p = 1'b1;
        ten_meg_mode <= 1'b1;
        half_duplex <= 1'b1;
        go <= 1'b1;
        for (int k = 0; k < 100; k++)
        begin
            @(posedge mclk);
            #1;
            if (tx_clk && !p && tx_en)
            begin
                check("loop", rxd, txd);
                check("dv", 4'(rx_dv), 4'h1);
                check("col", 4'(col), 4'h0);
            end
            p = tx_clk;
        end
        @(posedge mclk);
        go <= 1'b0;
        repeat (60) @(posedge mclk);
        for (int k = 0; k < 200 && enc_out !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
        end
        n = 0;
        // Width is counted in whole cycles of the system clock
        for (int k = 0; k < 20 && enc_out === 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("nlp", 4'(n), 4'(`FEPC_NLP_WIDTH_CYC));
    endtask

    initial
    begin
        #200000;
        fail_count++;
        report_and_stop;
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_tx100;
        t_rx100;
        t_lock;
        t_bad_ssd;
        t_rmii;
        t_ten;
        report_and_stop;
    end
endmodule

`default_nettype wire
